// >>> bench/addr_space_decoder_sva.sv
// checker of decode, bus strobes and clock pins
module addr_space_decoder_sva (
	input wire logic CLK,
	input wire logic RST,
	input wire logic REQ_VALID,
	input wire decoder_pkg::access_kind_t REQ_KIND,
	input wire logic [15:0] REQ_ADDR,
	input wire logic REQ_WE,
	input wire logic REQ_READY,
	input wire logic RSP_VALID,
	input wire logic FLASH_SEL,
	input wire logic SFR_SEL,
	input wire logic XFR_SEL,
	input wire logic [15:0] TGT_ADDR,
	input wire logic TGT_WE,
	input wire logic P0_OE,
	input wire logic ALE,
	input wire logic WR_N_OUT,
	input wire logic RD_N_OUT,
	input wire logic CPU_MULT_ENABLE_N,
	input wire logic CPU_MULT_ON,
	input wire logic PERIPH_CLK_FROM_CRYSTAL,
	input wire logic CRYSTAL_IN,
	input wire logic CRYSTAL_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	import decoder_pkg::*;
	logic tk;
	logic dp;
	logic [1:0] up_r;
	logic [1:0] up_nxt;
	assign tk = REQ_VALID && REQ_READY;
	assign dp = tk && REQ_KIND == K_XDATA_DPTR;
	// counts edges since reset so the pin pipelines are full
	always_comb up_nxt = (up_r == 2'h3) ? up_r : up_r + 2'h1;
	always_ff @(posedge CLK) up_r <= RST ? 2'h0 : up_nxt;
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	a_int_answer: assert property (tk && (!dp || REQ_ADDR < 16'h0900)
		|-> ##2 RSP_VALID) else $error("internal answer late");
	a_ext_answer: assert property (dp && REQ_ADDR > 16'h08ff
		|-> ##10 RSP_VALID) else $error("bus answer late");
	a_flash_ro: assert property (tk && REQ_KIND == K_CODE |=> FLASH_SEL
		&& !TGT_WE && TGT_ADDR == $past(REQ_ADDR)) else $error("flash");
	a_sfr_direct: assert property (tk && REQ_KIND == K_DIRECT
		&& REQ_ADDR[7] |=> SFR_SEL) else $error("sfr select");
	a_iram_only: assert property (tk && (REQ_KIND == K_INDIRECT
		|| (REQ_KIND == K_DIRECT && !REQ_ADDR[7])) |=> !SFR_SEL
		&& !XFR_SEL && !TGT_WE && !ALE) else $error("iram select");
	a_reg_write: assert property (tk && REQ_WE
		&& ((REQ_KIND == K_DIRECT && REQ_ADDR[7])
		|| (dp && REQ_ADDR < 16'h0020)) |=> TGT_WE
		&& (SFR_SEL || XFR_SEL)) else $error("register write");
	a_xfr_low: assert property (dp && REQ_ADDR < 16'h0020
		|=> XFR_SEL) else $error("xfr select");
	a_xram_map: assert property (dp && REQ_ADDR >= 16'h0020
		&& REQ_ADDR <= 16'h08ff |=> !XFR_SEL && !SFR_SEL && !ALE)
		else $error("xram select");
	a_ri_high: assert property (tk && REQ_KIND == K_XDATA_RI
		|=> TGT_ADDR[15:8] == 8'h00) else $error("ri high byte");
	a_ale_addr: assert property ($rose(ALE) |-> P0_OE ##2 !ALE)
		else $error("ale");
	a_rd_len: assert property ($fell(RD_N_OUT) |-> !RD_N_OUT[*6]
		##1 RD_N_OUT) else $error("rd strobe");
	a_wr_len: assert property ($fell(WR_N_OUT) |-> !WR_N_OUT[*6]
		##1 (WR_N_OUT && P0_OE)) else $error("wr strobe");
	a_mult_pin: assert property (up_r == 2'h3 |-> CPU_MULT_ON ==
		!$past(CPU_MULT_ENABLE_N, 3) && PERIPH_CLK_FROM_CRYSTAL ==
		$past(CPU_MULT_ENABLE_N, 3)) else $error("multiplier pin");
	a_xtal_pin: assert property (up_r == 2'h3 |-> CRYSTAL_OUT ==
		!$past(CRYSTAL_IN, 3)) else $error("crystal pin");
endmodule

bind addr_space_decoder addr_space_decoder_sva i_sva (
	.CLK(CLK),
	.RST(RST),
	.REQ_VALID(REQ_VALID),
	.REQ_KIND(REQ_KIND),
	.REQ_ADDR(REQ_ADDR),
	.REQ_WE(REQ_WE),
	.REQ_READY(REQ_READY),
	.RSP_VALID(RSP_VALID),
	.FLASH_SEL(FLASH_SEL),
	.SFR_SEL(SFR_SEL),
	.XFR_SEL(XFR_SEL),
	.TGT_ADDR(TGT_ADDR),
	.TGT_WE(TGT_WE),
	.P0_OE(P0_OE),
	.ALE(ALE),
	.WR_N_OUT(WR_N_OUT),
	.RD_N_OUT(RD_N_OUT),
	.CPU_MULT_ENABLE_N(CPU_MULT_ENABLE_N),
	.CPU_MULT_ON(CPU_MULT_ON),
	.PERIPH_CLK_FROM_CRYSTAL(PERIPH_CLK_FROM_CRYSTAL),
	.CRYSTAL_IN(CRYSTAL_IN),
	.CRYSTAL_OUT(CRYSTAL_OUT)
);

// >>> bench/addr_space_decoder_tb_top.sv
// testbench of the address space decoder
module addr_space_decoder_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import decoder_pkg::*;
	logic CLK, RST, REQ_VALID, REQ_WE, REQ_READY, RSP_VALID, TGT_WE;
	access_kind_t REQ_KIND;
	logic [15:0] REQ_ADDR, TGT_ADDR, LAT_ADDR;
	logic [7:0] REQ_WDATA, RSP_DATA, FLASH_RDATA, SFR_RDATA, XFR_RDATA;
	logic [7:0] P0_OUT, P0_IN, ADDR_HI, TGT_WDATA, WR_SEEN, rd;
	logic [1:0] REQ_BANK;
	logic FLASH_SEL, SFR_SEL, XFR_SEL, P0_OE, ALE, WR_N_OUT, WR_N_OE;
	logic RD_N_OUT, RD_N_OE, CPU_MULT_ENABLE_N, CPU_MULT_ON;
	logic PERIPH_CLK_FROM_CRYSTAL, CRYSTAL_IN, CRYSTAL_OUT;
	int miscompares, n_compared;

	addr_space_decoder i_dut (
		.CLK(CLK),
		.RST(RST),
		.REQ_VALID(REQ_VALID),
		.REQ_KIND(REQ_KIND),
		.REQ_ADDR(REQ_ADDR),
		.REQ_WE(REQ_WE),
		.REQ_WDATA(REQ_WDATA),
		.REQ_BANK(REQ_BANK),
		.REQ_READY(REQ_READY),
		.RSP_VALID(RSP_VALID),
		.RSP_DATA(RSP_DATA),
		.FLASH_SEL(FLASH_SEL),
		.SFR_SEL(SFR_SEL),
		.XFR_SEL(XFR_SEL),
		.TGT_ADDR(TGT_ADDR),
		.TGT_WE(TGT_WE),
		.TGT_WDATA(TGT_WDATA),
		.FLASH_RDATA(FLASH_RDATA),
		.SFR_RDATA(SFR_RDATA),
		.XFR_RDATA(XFR_RDATA),
		.P0_OUT(P0_OUT),
		.P0_OE(P0_OE),
		.P0_IN(P0_IN),
		.ADDR_HI(ADDR_HI),
		.ALE(ALE),
		.WR_N_OUT(WR_N_OUT),
		.WR_N_OE(WR_N_OE),
		.RD_N_OUT(RD_N_OUT),
		.RD_N_OE(RD_N_OE),
		.CPU_MULT_ENABLE_N(CPU_MULT_ENABLE_N),
		.CPU_MULT_ON(CPU_MULT_ON),
		.PERIPH_CLK_FROM_CRYSTAL(PERIPH_CLK_FROM_CRYSTAL),
		.CRYSTAL_IN(CRYSTAL_IN),
		.CRYSTAL_OUT(CRYSTAL_OUT)
	);
	target_model i_tgt (
		.CLK(CLK),
		.TGT_ADDR(TGT_ADDR),
		.P0_OUT(P0_OUT),
		.ADDR_HI(ADDR_HI),
		.ALE(ALE),
		.RD_N_OUT(RD_N_OUT),
		.WR_N_OUT(WR_N_OUT),
		.FLASH_RDATA(FLASH_RDATA),
		.SFR_RDATA(SFR_RDATA),
		.XFR_RDATA(XFR_RDATA),
		.P0_IN(P0_IN),
		.LAT_ADDR(LAT_ADDR),
		.WR_SEEN(WR_SEEN)
	);

	initial begin
		CLK = 1'b0;
		forever #4 CLK = ~CLK;
	end

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// one access, held until taken, then waits for its answer
	task automatic acc(input access_kind_t k, input logic [15:0] a,
		input logic w = 1'b0, input logic [7:0] d = 8'h00,
		input logic [1:0] b = 2'h0);
		int i;
		@(negedge CLK);
		REQ_KIND = k;
		REQ_ADDR = a;
		REQ_WE = w;
		REQ_WDATA = d;
		REQ_BANK = b;
		REQ_VALID = 1'b1;
		for (i = 0; i < 20 && REQ_READY !== 1'b1; i++)
			@(negedge CLK);
		if (i == 20) begin
			$display("[ERR] %0t ready timeout got %h exp %h", $time,
				REQ_READY, 1'b1);
			miscompares++;
			stop_test();
		end
		@(negedge CLK);
		REQ_VALID = 1'b0;
		for (i = 0; i < 20 && RSP_VALID !== 1'b1; i++)
			@(negedge CLK);
		if (i == 20) begin
			$display("[ERR] %0t answer timeout got %h exp %h", $time,
				RSP_VALID, 1'b1);
			miscompares++;
			stop_test();
		end
		rd = RSP_DATA;
	endtask

	task automatic t_reset;
		chk({9'h0, REQ_READY, ALE, P0_OE, RD_N_OUT, WR_N_OUT, RD_N_OE,
			WR_N_OE}, 16'h004f);
		$display("reset test done");
	endtask

	task automatic t_spaces;
		acc(K_CODE, 16'hbeef);
		chk(16'(rd), 16'h0051);
		acc(K_CODE, 16'hbeef, 1'b1, 8'h11);
		acc(K_DIRECT, 16'h0042, 1'b1, 8'h5a);
		acc(K_INDIRECT, 16'h0042);
		chk(16'(rd), 16'h005a);
		acc(K_INDIRECT, 16'h0090, 1'b1, 8'hc3);
		acc(K_DIRECT, 16'h0090);
		chk(16'(rd), 16'h006f);
		acc(K_DIRECT, 16'h00a5, 1'b1, 8'h3c);
		chk({TGT_ADDR[7:0], TGT_WDATA}, 16'ha53c);
		acc(K_INDIRECT, 16'h0090);
		chk(16'(rd), 16'h00c3);
		acc(K_REGFILE, 16'h0003, 1'b1, 8'h77, 2'h1);
		acc(K_DIRECT, 16'h000b);
		chk(16'(rd), 16'h0077);
		$display("spaces test done");
	endtask

	task automatic t_xdata;
		acc(K_XDATA_DPTR, 16'h001f);
		chk(16'(rd), 16'h005f);
		acc(K_XDATA_DPTR, 16'h0000);
		chk(16'(rd), 16'h0040);
		acc(K_XDATA_DPTR, 16'h0011, 1'b1, 8'h6b);
		chk({TGT_ADDR[7:0], TGT_WDATA}, 16'h116b);
		acc(K_XDATA_DPTR, 16'h0020, 1'b1, 8'h21);
		acc(K_XDATA_DPTR, 16'h08ff, 1'b1, 8'h9e);
		acc(K_XDATA_DPTR, 16'h08ff);
		chk(16'(rd), 16'h009e);
		acc(K_XDATA_RI, 16'h1220);
		chk(16'(rd), 16'h0021);
		chk(TGT_ADDR, 16'h0020);
		$display("xdata test done");
	endtask

	task automatic t_extbus;
		acc(K_XDATA_DPTR, 16'h0a5c, 1'b1, 8'he7);
		chk(LAT_ADDR, 16'h0a5c);
		chk(16'(WR_SEEN), 16'h00e7);
		acc(K_XDATA_DPTR, 16'h0933);
		chk(16'(rd), 16'h0096);
		$display("external bus test done");
	endtask

	task automatic t_midreset;
		@(negedge CLK);
		RST = 1'b1;
		repeat (2) @(negedge CLK);
		chk({15'h0, REQ_READY}, 16'h0000);
		RST = 1'b0;
		repeat (2) @(negedge CLK);
		chk({15'h0, REQ_READY}, 16'h0001);
		acc(K_INDIRECT, 16'h0042);
		chk(16'(rd), 16'h005a);
		$display("mid-run reset test done");
	endtask

	task automatic t_clocks;
		int i;
		for (i = 0; i < 4; i++) begin
			CPU_MULT_ENABLE_N = i[0];
			CRYSTAL_IN = i[1];
			repeat (4) @(negedge CLK);
			chk({13'h0, CPU_MULT_ON, PERIPH_CLK_FROM_CRYSTAL, CRYSTAL_OUT},
				{13'h0, ~i[0], i[0], ~i[1]});
		end
		$display("clock pin test done");
	endtask

	initial begin
		RST = 1'b1;
		REQ_VALID = 1'b0;
		REQ_KIND = K_CODE;
		REQ_ADDR = 16'h0000;
		REQ_WE = 1'b0;
		REQ_WDATA = 8'h00;
		REQ_BANK = 2'h0;
		CPU_MULT_ENABLE_N = 1'b1;
		CRYSTAL_IN = 1'b0;
		repeat (5) @(negedge CLK);
		RST = 1'b0;
		repeat (2) @(negedge CLK);
		t_reset();
		t_spaces();
		t_xdata();
		t_extbus();
		t_midreset();
		t_clocks();
		stop_test();
	end
endmodule

// >>> bench/target_model.sv
// far side: register blocks, flash and an address latch with a fixed read pattern on the external bus
module target_model (
	input wire logic CLK,
	input wire logic [15:0] TGT_ADDR,
	input wire logic [7:0] P0_OUT,
	input wire logic [7:0] ADDR_HI,
	input wire logic ALE,
	input wire logic RD_N_OUT,
	input wire logic WR_N_OUT,
	output logic [7:0] FLASH_RDATA,
	output logic [7:0] SFR_RDATA,
	output logic [7:0] XFR_RDATA,
	output logic [7:0] P0_IN,
	output logic [15:0] LAT_ADDR,
	output logic [7:0] WR_SEEN
);
	timeunit 1ns;
	timeprecision 1ps;
	assign FLASH_RDATA = TGT_ADDR[7:0] ^ TGT_ADDR[15:8];
	assign SFR_RDATA = ~TGT_ADDR[7:0];
	assign XFR_RDATA = TGT_ADDR[7:0] + 8'h40;
	// port 0 pulls low, so a released bus reads zero
	assign P0_IN = RD_N_OUT ? 8'h00 : LAT_ADDR[7:0] ^ 8'ha5;
	always_ff @(posedge CLK) begin
		if (ALE)
			LAT_ADDR <= {ADDR_HI, P0_OUT};
		if (!WR_N_OUT)
			WR_SEEN <= P0_OUT;
	end
endmodule

// >>> src/addr_space_decoder.sv
// address space decoder with external bus pins and clock pins
// Summary of operation
// - decode six separate address spaces
// - 64K flash code space, read only
// - extra RAM at external data 0020H-08FFH
// - 32 external function registers at 00H-1FH
// - lower internal RAM, direct and indirect
// - upper internal RAM, indirect only
// - direct 80H-FFH goes to special registers
// - four banks of eight byte register file R0-R7
// - low pin enables CPU clock multiplier
// - high pin disables multiplier, crystal clocks
// - crystal or external clock on crystal input
// - port 0 carries muxed address and data
// - port 3 bit 6 is write strobe
// - port 3 bit 7 is read strobe
// - register indirect moves force high byte zero
module addr_space_decoder (
	input wire logic CLK,
	input wire logic RST,
	input wire logic REQ_VALID,
	input wire decoder_pkg::access_kind_t REQ_KIND,
	input wire logic [15:0] REQ_ADDR,
	input wire logic REQ_WE,
	input wire logic [7:0] REQ_WDATA,
	input wire logic [1:0] REQ_BANK,
	output logic REQ_READY,
	output logic RSP_VALID,
	output logic [7:0] RSP_DATA,
	output logic FLASH_SEL,
	output logic SFR_SEL,
	output logic XFR_SEL,
	output logic [15:0] TGT_ADDR,
	output logic TGT_WE,
	output logic [7:0] TGT_WDATA,
	input wire logic [7:0] FLASH_RDATA,
	input wire logic [7:0] SFR_RDATA,
	input wire logic [7:0] XFR_RDATA,
	output logic [7:0] P0_OUT,
	output logic P0_OE,
	input wire logic [7:0] P0_IN,
	output logic [7:0] ADDR_HI,
	output logic ALE,
	output logic WR_N_OUT,
	output logic WR_N_OE,
	output logic RD_N_OUT,
	output logic RD_N_OE,
	input wire logic CPU_MULT_ENABLE_N,
	output logic CPU_MULT_ON,
	output logic PERIPH_CLK_FROM_CRYSTAL,
	input wire logic CRYSTAL_IN,
	output logic CRYSTAL_OUT
);
	import decoder_pkg::*;

	// effective address after forcing and register file folding
	function automatic logic [15:0] eff_addr(access_kind_t k,
		logic [15:0] a, logic [1:0] bank);
		case (k)
			K_XDATA_RI: eff_addr = {RI_HIGH_BYTE, a[7:0]};
			K_REGFILE: eff_addr = {11'h000, bank, a[2:0]};
			K_DIRECT, K_INDIRECT: eff_addr = {8'h00, a[7:0]};
			default: eff_addr = a;
		endcase
	endfunction

	function automatic target_t target_of(access_kind_t k, logic [15:0] a);
		case (k)
			K_CODE: target_of = T_FLASH;
			K_DIRECT: begin
				if (a[SFR_SPACE_BIT]) begin
					target_of = T_SFR;
				end else begin
					target_of = T_IRAM;
				end
			end
			K_INDIRECT, K_REGFILE: target_of = T_IRAM;
			K_XDATA_RI, K_XDATA_DPTR: begin
				if (a <= XFR_LAST) begin
					target_of = T_XFR;
				end else if (a <= XRAM_LAST) begin
					target_of = T_XRAM;
				end else begin
					target_of = T_EXT;
				end
			end
			default: target_of = T_IRAM;
		endcase
	endfunction

	function automatic logic [11:0] mem_index(target_t t, logic [15:0] a);
		logic [15:0] off;
		off = a - XRAM_FIRST;
		if (t == T_XRAM) begin
			mem_index = XRAM_BASE_INDEX + off[11:0];
		end else begin
			mem_index = {4'h0, a[7:0]};
		end
	endfunction

	mem_port_if mem ();

	ram_store u_store (
		.CLK(CLK),
		.port(mem)
	);

	bus_state_t state_r, state_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	target_t tgt_r, tgt_nxt;
	logic [15:0] addr_r, addr_nxt;
	logic we_r, we_nxt;
	logic [7:0] wdata_r, wdata_nxt;
	logic ready_r, ready_nxt;
	logic rsp_valid_r, rsp_valid_nxt;
	logic [7:0] rsp_data_r, rsp_data_nxt;
	logic flash_sel_r, flash_sel_nxt;
	logic sfr_sel_r, sfr_sel_nxt;
	logic xfr_sel_r, xfr_sel_nxt;
	logic tgt_we_r, tgt_we_nxt;
	logic [7:0] p0_out_r, p0_out_nxt;
	logic p0_oe_r, p0_oe_nxt;
	logic ale_r, ale_nxt;
	logic wr_n_r, wr_n_nxt;
	logic rd_n_r, rd_n_nxt;
	logic strobe_oe_r;

	// pin side synchronisers and clock controls
	logic [7:0] p0_meta_r, p0_sync_r;
	logic mult_meta_r, mult_sync_r;
	logic xtal_meta_r, xtal_sync_r;
	logic mult_on_r, mult_on_nxt;
	logic periph_xtal_r, periph_xtal_nxt;
	logic xtal_out_r, xtal_out_nxt;

	always_comb begin
		logic [15:0] ea;
		target_t t;
		ea = eff_addr(REQ_KIND, REQ_ADDR, REQ_BANK);
		t = target_of(REQ_KIND, ea);
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		tgt_nxt = tgt_r;
		addr_nxt = addr_r;
		we_nxt = we_r;
		wdata_nxt = wdata_r;
		rsp_valid_nxt = 1'b0;
		rsp_data_nxt = rsp_data_r;
		mem.addr = mem_index(t, ea);
		mem.we = 1'b0;
		mem.wdata = REQ_WDATA;
		case (state_r)
			S_IDLE: begin
				if (REQ_VALID && ready_r) begin
					tgt_nxt = t;
					addr_nxt = ea;
					we_nxt = REQ_WE;
					wdata_nxt = REQ_WDATA;
					mem.we = REQ_WE && (t == T_IRAM || t == T_XRAM);
					if (t == T_EXT) begin
						state_nxt = S_ALE;
						cnt_nxt = ALE_CYC - CNT_STEP;
					end else begin
						state_nxt = S_WAIT;
					end
				end
			end
			S_WAIT: begin
				rsp_valid_nxt = 1'b1;
				if (!we_r) begin
					case (tgt_r)
						T_FLASH: rsp_data_nxt = FLASH_RDATA;
						T_SFR: rsp_data_nxt = SFR_RDATA;
						T_XFR: rsp_data_nxt = XFR_RDATA;
						default: rsp_data_nxt = mem.rdata;
					endcase
				end
				state_nxt = S_IDLE;
			end
			S_ALE: begin
				if (cnt_r == CNT_ZERO) begin
					state_nxt = S_STROBE;
					cnt_nxt = STROBE_CYC - CNT_STEP;
				end else begin
					cnt_nxt = cnt_r - CNT_STEP;
				end
			end
			S_STROBE: begin
				if (cnt_r == CNT_ZERO) begin
					state_nxt = S_RECOVER;
					if (!we_r) begin
						rsp_data_nxt = p0_sync_r;
					end
				end else begin
					cnt_nxt = cnt_r - CNT_STEP;
				end
			end
			S_RECOVER: begin
				rsp_valid_nxt = 1'b1;
				state_nxt = S_IDLE;
			end
			default: state_nxt = S_IDLE;
		endcase
		ready_nxt = state_nxt == S_IDLE;
		flash_sel_nxt = state_nxt == S_WAIT && tgt_nxt == T_FLASH;
		sfr_sel_nxt = state_nxt == S_WAIT && tgt_nxt == T_SFR;
		xfr_sel_nxt = state_nxt == S_WAIT && tgt_nxt == T_XFR;
		// flash is never written through this path
		tgt_we_nxt = state_nxt == S_WAIT && we_nxt &&
			(tgt_nxt == T_SFR || tgt_nxt == T_XFR);
		ale_nxt = state_nxt == S_ALE;
		if (state_nxt == S_ALE) begin
			p0_out_nxt = addr_nxt[7:0];
		end else begin
			p0_out_nxt = wdata_nxt;
		end
		// data is held one cycle past the write strobe
		p0_oe_nxt = state_nxt == S_ALE ||
			(we_nxt && (state_nxt == S_STROBE ||
			state_nxt == S_RECOVER));
		wr_n_nxt = !(state_nxt == S_STROBE && we_nxt);
		rd_n_nxt = !(state_nxt == S_STROBE && !we_nxt);
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			state_r <= S_IDLE;
			cnt_r <= CNT_ZERO;
			tgt_r <= T_IRAM;
			addr_r <= 16'h0000;
			we_r <= 1'b0;
			wdata_r <= 8'h00;
			ready_r <= 1'b0;
			rsp_valid_r <= 1'b0;
			rsp_data_r <= 8'h00;
			flash_sel_r <= 1'b0;
			sfr_sel_r <= 1'b0;
			xfr_sel_r <= 1'b0;
			tgt_we_r <= 1'b0;
			p0_out_r <= 8'h00;
			p0_oe_r <= 1'b0;
			ale_r <= 1'b0;
			wr_n_r <= STROBE_IDLE;
			rd_n_r <= STROBE_IDLE;
			strobe_oe_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			tgt_r <= tgt_nxt;
			addr_r <= addr_nxt;
			we_r <= we_nxt;
			wdata_r <= wdata_nxt;
			ready_r <= ready_nxt;
			rsp_valid_r <= rsp_valid_nxt;
			rsp_data_r <= rsp_data_nxt;
			flash_sel_r <= flash_sel_nxt;
			sfr_sel_r <= sfr_sel_nxt;
			xfr_sel_r <= xfr_sel_nxt;
			tgt_we_r <= tgt_we_nxt;
			p0_out_r <= p0_out_nxt;
			p0_oe_r <= p0_oe_nxt;
			ale_r <= ale_nxt;
			wr_n_r <= wr_n_nxt;
			rd_n_r <= rd_n_nxt;
			strobe_oe_r <= 1'b1;
		end
	end

	always_comb begin
		mult_on_nxt = !mult_sync_r;
		periph_xtal_nxt = mult_sync_r;
		// inverting oscillator stage; harmless when a clock drives the input
		xtal_out_nxt = !xtal_sync_r;
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			p0_meta_r <= 8'h00;
			p0_sync_r <= 8'h00;
			mult_meta_r <= MULT_N_RESET;
			mult_sync_r <= MULT_N_RESET;
			xtal_meta_r <= 1'b0;
			xtal_sync_r <= 1'b0;
			mult_on_r <= 1'b0;
			periph_xtal_r <= 1'b1;
			xtal_out_r <= 1'b1;
		end else begin
			p0_meta_r <= P0_IN;
			p0_sync_r <= p0_meta_r;
			mult_meta_r <= CPU_MULT_ENABLE_N;
			mult_sync_r <= mult_meta_r;
			xtal_meta_r <= CRYSTAL_IN;
			xtal_sync_r <= xtal_meta_r;
			mult_on_r <= mult_on_nxt;
			periph_xtal_r <= periph_xtal_nxt;
			xtal_out_r <= xtal_out_nxt;
		end
	end

	assign REQ_READY = ready_r;
	assign RSP_VALID = rsp_valid_r;
	assign RSP_DATA = rsp_data_r;
	assign FLASH_SEL = flash_sel_r;
	assign SFR_SEL = sfr_sel_r;
	assign XFR_SEL = xfr_sel_r;
	assign TGT_ADDR = addr_r;
	assign TGT_WE = tgt_we_r;
	assign TGT_WDATA = wdata_r;
	assign P0_OUT = p0_out_r;
	assign P0_OE = p0_oe_r;
	assign ADDR_HI = addr_r[15:8];
	assign ALE = ale_r;
	assign WR_N_OUT = wr_n_r;
	assign WR_N_OE = strobe_oe_r;
	assign RD_N_OUT = rd_n_r;
	assign RD_N_OE = strobe_oe_r;
	assign CPU_MULT_ON = mult_on_r;
	assign PERIPH_CLK_FROM_CRYSTAL = periph_xtal_r;
	assign CRYSTAL_OUT = xtal_out_r;
endmodule

// >>> src/decoder_pkg.sv
// constants and types shared by the address space decoder
package decoder_pkg;
	localparam int CLK_PERIOD_NS = 8;
	// least widths of the address phase and of a strobe on the external bus
	localparam int ALE_MIN_NS = 16;
	localparam int STROBE_MIN_NS = 48;
	localparam logic [3:0] ALE_CYC =
		4'((ALE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] STROBE_CYC =
		4'((STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	localparam logic [15:0] CODE_LAST = 16'hffff;
	localparam logic [15:0] XFR_LAST = 16'h001f;
	localparam logic [15:0] XRAM_FIRST = 16'h0020;
	localparam logic [15:0] XRAM_LAST = 16'h08ff;
	localparam logic [7:0] RI_HIGH_BYTE = 8'h00;
	localparam int SFR_SPACE_BIT = 7;
	localparam int IRAM_DEPTH = 256;
	localparam int XRAM_DEPTH = 2304 - 32;
	localparam int MEM_DEPTH = IRAM_DEPTH + XRAM_DEPTH;
	localparam int MEM_AW = 12;
	localparam logic [11:0] XRAM_BASE_INDEX = 12'h100;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [3:0] CNT_STEP = 4'h1;

	// reset values of the pin side
	localparam logic MULT_N_RESET = 1'b1;
	localparam logic STROBE_IDLE = 1'b1;

	typedef enum logic [2:0] {
		K_CODE = 3'h0,
		K_DIRECT = 3'h1,
		K_INDIRECT = 3'h2,
		K_REGFILE = 3'h3,
		K_XDATA_RI = 3'h4,
		K_XDATA_DPTR = 3'h5
	} access_kind_t;

	typedef enum logic [2:0] {
		T_FLASH = 3'h0,
		T_IRAM = 3'h1,
		T_SFR = 3'h2,
		T_XFR = 3'h3,
		T_XRAM = 3'h4,
		T_EXT = 3'h5
	} target_t;

	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_WAIT = 5'b00010,
		S_ALE = 5'b00100,
		S_STROBE = 5'b01000,
		S_RECOVER = 5'b10000
	} bus_state_t;
endpackage

// >>> src/mem_port_if.sv
// port between the decoder and its on-chip data store
interface mem_port_if;
	logic [11:0] addr;
	logic we;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport ctl (output addr, output we, output wdata, input rdata);
	modport store (input addr, input we, input wdata, output rdata);
endinterface

// >>> src/ram_store.sv
// single port data store for internal and extra RAM, registered read
module ram_store (
	input wire logic CLK,
	mem_port_if.store port
);
	import decoder_pkg::*;

	logic [7:0] cells [MEM_DEPTH];
	logic [7:0] rdata_r;

	always_ff @(posedge CLK) begin
		if (port.we) begin
			cells[port.addr] <= port.wdata;
		end
		rdata_r <= cells[port.addr];
	end

	assign port.rdata = rdata_r;
endmodule
